// File: core/host_rx_defines.svh
// constants for the parallel host receiver
`ifndef HOST_RX_DEFINES_SVH
`define HOST_RX_DEFINES_SVH
`define CLASS_BIT       7
`define FIRST_BYTE_BIT  6
`define ROTARY_INTERNAL_PATTERN_POSITION     3'h0
`define PATTERN_CONV    4'hD
`define ROTARY_CONV     3'h2
`define STORE_PULSE_NS  50
`define CLK_PERIOD_NS   25
`define STORE_CYCLES    ((`STORE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: core/host_rx_pkg.sv
// types for the parallel host receiver
package host_rx_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_STORE = 2'b01,
    ST_ACK   = 2'b10,
    ST_CMD   = 2'b11
  } rx_state_t;
endpackage

// File: core/parallel_print_host_receiver.sv
// host-facing byte receiver, demultiplexer, handshakes and index sync
`timescale 1ns/1ps
`include "host_rx_defines.svh"
module parallel_print_host_receiver #(
  parameter int STORE_LEN = `STORE_CYCLES
) (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire logic [7:0]             host_data_in,
  input  wire logic                   host_byte_strobe_n_in,
  input  wire logic                   combined_index_pulse_in,
  input  wire logic                   latch_output_float_in,
  input  wire logic                   pixel_width_select_in,
  input  wire logic                   processor_acknowledge_in,
  input  wire logic                   streaming_ack_suppress_n_in,
  input  wire logic                   processor_clear_strobe_in,
  input  wire logic                   machine_ready_status_n_in,
  input  wire logic                   no_ink_in,
  input  wire logic                   no_paper_in,
  input  wire logic                   byte_rejected_in,
  input  wire logic [2:0]             rotary_select_in,
  input  wire logic [3:0]             dip_switch_in,
  input  wire logic                   pattern_start_in,
  output logic [7:0]                  internal_byte_bus_out,
  output logic                        internal_byte_bus_oe_n_out,
  output logic                        command_interrupt_input_out,
  output logic                        buffer_store_strobe_n_out,
  output logic [3:0]                  red_out,
  output logic [3:0]                  green_out,
  output logic [3:0]                  blue_out,
  output logic                        host_ack_n_out,
  output logic                        host_fault_n_out,
  output logic                        host_busy_out,
  output logic                        synced_index_pulse_out,
  output logic                        index_count_start_out,
  output logic [3:0]                  pattern_number_out,
  output logic                        pattern_run_out
);
  import host_rx_pkg::*;

  // the store counter is eight bits wide
  if (STORE_LEN < 1 || STORE_LEN > 255) begin
    $error("STORE_LEN out of range");
  end

  // pin inputs: two flip-flops each before use
  logic [7:0] data_s1, data_s2;
  logic [13:0] pin_s1, pin_s2;
  logic [13:0] pins_raw;
  assign pins_raw = {host_byte_strobe_n_in, combined_index_pulse_in,
                     streaming_ack_suppress_n_in, machine_ready_status_n_in,
                     no_ink_in, no_paper_in, rotary_select_in,
                     dip_switch_in, pattern_start_in};
  always_ff @(posedge clk_in) begin
    data_s1 <= host_data_in;
    data_s2 <= data_s1;
    pin_s1  <= pins_raw;
    pin_s2  <= pin_s1;
  end
  logic       strobe_n, index_lvl, stream_n, mrdy_n, ink_out, paper_out;
  logic [2:0] rotary;
  logic [3:0] dips;
  logic       start_btn;
  assign {strobe_n, index_lvl, stream_n, mrdy_n, ink_out, paper_out,
          rotary, dips, start_btn} = pin_s2;

  rx_state_t  state, next_state;
  logic       strobe_d, index_d, start_d;
  logic [7:0] latch, next_latch;
  logic [3:0] red, green, blue, next_red, next_green, next_blue;
  logic [7:0] cnt, next_cnt;
  logic       fault, next_fault;
  logic       busy, next_busy;
  logic [3:0] pattern, next_pattern;
  logic       run, next_run;
  logic       conv_active, next_conv_active;
  logic       strobe_fall, start_rise;

  assign strobe_fall = strobe_d & ~strobe_n;
  assign start_rise  = start_btn & ~start_d;

  always_comb begin
    next_state       = state;
    next_latch       = latch;
    next_red         = red;
    next_green       = green;
    next_blue        = blue;
    next_cnt         = cnt;
    next_fault       = fault;
    next_busy        = busy;
    next_pattern     = pattern;
    next_run         = run;
    next_conv_active = conv_active;
    case (state)
      ST_IDLE: begin
        if (strobe_fall) begin
          next_latch = data_s2;
          next_fault = 1'b0;
          if (data_s2[`CLASS_BIT]) begin
            next_state = ST_STORE;
            next_cnt   = 8'(STORE_LEN);
            if (data_s2[`FIRST_BYTE_BIT]) begin
              // first byte or one-byte pixel: upper two bits
              next_red   = {data_s2[5:4], 2'b00};
              next_green = {data_s2[3:2], 2'b00};
              next_blue  = {data_s2[1:0], 2'b00};
            end else if (pixel_width_select_in) begin
              // second byte gated through only in two-byte mode
              next_red[1:0]   = data_s2[5:4];
              next_green[1:0] = data_s2[3:2];
              next_blue[1:0]  = data_s2[1:0];
            end
          end else begin
            next_state = ST_CMD;
          end
        end
      end
      ST_STORE: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
      ST_CMD: begin
        if (processor_clear_strobe_in) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // set wins over the strobe clear
    if (ink_out || paper_out || byte_rejected_in) begin
      next_fault = 1'b1;
    end
    next_busy = mrdy_n | fault;
    // pattern selection, sampled when the run begins
    if (start_rise) begin
      if (run && conv_active) begin
        next_run = 1'b0;
        next_conv_active = 1'b0;
      end else if (!run) begin
        next_run = 1'b1;
        if (rotary == `ROTARY_INTERNAL_PATTERN_POSITION) begin
          next_pattern = dips;
        end else begin
          // dips are or-ed in, so closed dips corrupt the choice
          next_pattern = {1'b0, rotary} | dips;
        end
        next_conv_active = (rotary == `ROTARY_CONV && dips == 4'h0) ||
                           (rotary == `ROTARY_INTERNAL_PATTERN_POSITION &&
                            dips == `PATTERN_CONV);
      end
    end
    // no copy-end input here: a run ends at reset or a convergence stop
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state       <= ST_IDLE;
      strobe_d    <= 1'b1;
      index_d     <= 1'b0;
      start_d     <= 1'b0;
      latch       <= 8'h00;
      red         <= 4'h0;
      green       <= 4'h0;
      blue        <= 4'h0;
      cnt         <= 8'h00;
      fault       <= 1'b0;
      busy        <= 1'b1;
      pattern     <= 4'h0;
      run         <= 1'b0;
      conv_active <= 1'b0;
    end else begin
      state       <= next_state;
      strobe_d    <= strobe_n;
      index_d     <= index_lvl;
      start_d     <= start_btn;
      latch       <= next_latch;
      red         <= next_red;
      green       <= next_green;
      blue        <= next_blue;
      cnt         <= next_cnt;
      fault       <= next_fault;
      busy        <= next_busy;
      pattern     <= next_pattern;
      run         <= next_run;
      conv_active <= next_conv_active;
    end
  end

  assign internal_byte_bus_out       = latch;
  assign internal_byte_bus_oe_n_out  = latch_output_float_in;
  assign command_interrupt_input_out = (state == ST_CMD);
  assign buffer_store_strobe_n_out   = ~(state == ST_STORE);
  assign red_out                     = red;
  assign green_out                   = green;
  assign blue_out                    = blue;
  // streaming mode blocks both ack sources
  assign host_ack_n_out = ~(stream_n &
                            ((state == ST_ACK) ||
                             (state == ST_CMD && processor_acknowledge_in)));
  assign host_fault_n_out       = ~fault;
  assign host_busy_out          = busy;
  assign synced_index_pulse_out = index_d;
  // one clock-wide start on each synced rising edge
  assign index_count_start_out  = index_lvl & ~index_d;
  assign pattern_number_out     = pattern;
  assign pattern_run_out        = run;

  a_cmd_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    state == ST_CMD && !processor_clear_strobe_in |=> state == ST_CMD)
    else $error("command state left without clear strobe");
  a_data_store: assert property (@(posedge clk_in) disable iff (reset_in)
    state == ST_IDLE && strobe_fall && data_s2[7] |=>
    !buffer_store_strobe_n_out)
    else $error("data byte gave no store strobe");
  a_cmd_irq: assert property (@(posedge clk_in) disable iff (reset_in)
    state == ST_IDLE && strobe_fall && !data_s2[7] |=>
    command_interrupt_input_out)
    else $error("command byte gave no interrupt");
  a_stream_noack: assert property (@(posedge clk_in) disable iff (reset_in)
    !stream_n |-> host_ack_n_out)
    else $error("ack sent in streaming mode");
  a_data_ack: assert property (@(posedge clk_in) disable iff (reset_in)
    state == ST_STORE && cnt == 8'h01 && stream_n |=> !host_ack_n_out)
    else $error("data byte not acknowledged");
  a_fault_set: assert property (@(posedge clk_in) disable iff (reset_in)
    ink_out |=> !host_fault_n_out)
    else $error("fault missing on ink out");
  a_busy_ready: assert property (@(posedge clk_in) disable iff (reset_in)
    mrdy_n |=> host_busy_out)
    else $error("busy dropped before machine ready");
  a_latch_byte: assert property (@(posedge clk_in) disable iff (reset_in)
    state == ST_IDLE && strobe_fall |=> latch == $past(data_s2))
    else $error("byte not latched");
  a_internal_pattern_position_pick: assert property (@(posedge clk_in) disable iff (reset_in)
    start_rise && !run && rotary == 3'h0 |=> pattern == $past(dips))
    else $error("dip code not used");
  c_data_byte: cover property (@(posedge clk_in) state == ST_STORE);
  c_cmd_byte: cover property (@(posedge clk_in) state == ST_CMD);
  c_conv_stop: cover property (@(posedge clk_in) conv_active && !next_run);
endmodule

// File: tb/host_model.sv
// host side model: presents bytes and strobes them into the receiver
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_in,
  input  wire logic host_ack_n_out,
  output logic [7:0] host_data_in,
  output logic       host_byte_strobe_n_in
);
  initial begin
    host_data_in = 8'h00;
    host_byte_strobe_n_in = 1'b1;
  end
  // data settles ahead of the strobe since both pass the same syncs
  task automatic send(input logic [7:0] b, input bit want, output bit got);
    int n;
    got = 1'b0;
    @(negedge clk_in) host_data_in = b;
    repeat (2) @(negedge clk_in);
    host_byte_strobe_n_in = 1'b0;
    for (n = 0; n < (want ? 40 : 10) && !got; n++) begin
      @(posedge clk_in);
      got = (host_ack_n_out === 1'b0);
    end
    @(negedge clk_in) host_byte_strobe_n_in = 1'b1;
    host_data_in = ~b; // released lines no longer hold the byte
  endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the parallel host receiver
`timescale 1ns/1ps
module tb;
  localparam int SL = 2;
  logic clk_in, reset_in, combined_index_pulse_in, latch_output_float_in;
  logic pixel_width_select_in, processor_acknowledge_in, no_ink_in;
  logic streaming_ack_suppress_n_in, processor_clear_strobe_in;
  logic machine_ready_status_n_in, no_paper_in, byte_rejected_in;
  logic pattern_start_in, host_byte_strobe_n_in, command_interrupt_input_out;
  logic [2:0] rotary_select_in;
  logic [3:0] dip_switch_in, red_out, green_out, blue_out, pattern_number_out;
  logic [7:0] host_data_in, internal_byte_bus_out;
  logic internal_byte_bus_oe_n_out, buffer_store_strobe_n_out, host_ack_n_out;
  logic host_fault_n_out, host_busy_out, synced_index_pulse_out;
  logic index_count_start_out, pattern_run_out;
  int fail_count, comparisons, stores, acks, starts, syncs, i, e;
  bit a;
  parallel_print_host_receiver #(.STORE_LEN(SL)) u_dut (.*);
  host_model u_host (.*);
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    stores += (buffer_store_strobe_n_out === 1'b0);
    acks += (host_ack_n_out === 1'b0);
    starts += (index_count_start_out === 1'b1);
    syncs += (synced_index_pulse_out === 1'b1);
  end
  task automatic check(input logic [7:0] g, e, input string m);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic byte_ok(input logic [7:0] b, input logic [3:0] c);
    stores = 0;
    u_host.send(b, 1, a);
    check(a, 1, "no ack");
    if (!a) give_verdict;
    check(stores, SL, "store length");
    check({red_out, green_out}, {c, c}, "red green");
    check(blue_out, c, "blue");
  endtask
  task t_pixels;
    pixel_width_select_in = 1'b0;
    byte_ok(8'hFF, 4'hC);
    byte_ok(8'hC0, 4'h0);
    byte_ok(8'hBF, 4'h0);
    pixel_width_select_in = 1'b1;
    byte_ok(8'hFF, 4'hC);
    byte_ok(8'hBF, 4'hF);
    $display("test pixels done");
  endtask
  task t_command;
    u_host.send(8'h35, 0, a);
    check(a, 0, "ack before done");
    check(command_interrupt_input_out, 1, "irq");
    check(internal_byte_bus_out, 8'h35, "latched byte");
    check(internal_byte_bus_oe_n_out, 0, "bus driven");
    latch_output_float_in = 1'b1;
    @(negedge clk_in) check(internal_byte_bus_oe_n_out, 1, "float");
    latch_output_float_in = 1'b0;
    processor_acknowledge_in = 1'b1;
    #1 check(host_ack_n_out, 0, "proc ack");
    @(negedge clk_in) processor_acknowledge_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check(command_interrupt_input_out, 1, "held");
    processor_clear_strobe_in = 1'b1;
    @(negedge clk_in) processor_clear_strobe_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check(command_interrupt_input_out, 0, "cleared");
    byte_ok(8'hC0, 4'h0);
    $display("test command done");
  endtask
  task t_stream;
    streaming_ack_suppress_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    {stores, acks} = 0;
    u_host.send(8'hFF, 0, a);
    check(acks, 0, "stream ack");
    check(stores, SL, "stream store");
    streaming_ack_suppress_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    $display("test stream done");
  endtask
  task t_fault;
    check(host_busy_out, 1, "busy not ready");
    machine_ready_status_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check({host_busy_out, host_fault_n_out}, 2'b01, "ready");
    for (i = 0; i < 3; i++) begin
      {no_ink_in, no_paper_in, byte_rejected_in} = 3'h4 >> i;
      @(negedge clk_in) byte_rejected_in = 1'b0;
      repeat (3) @(negedge clk_in);
      check({host_busy_out, host_fault_n_out}, 2'b10, "fault");
      {no_ink_in, no_paper_in} = 2'b00;
      repeat (3) @(negedge clk_in);
      check(host_fault_n_out, 0, "fault stands");
      u_host.send(8'hC0, 1, a);
      check(a, 1, "ack after fault");
      check(host_fault_n_out, 1, "fault cleared");
    end
    $display("test fault done");
  endtask
  task t_index;
    {starts, syncs} = 0;
    combined_index_pulse_in = 1'b1;
    repeat (3) @(negedge clk_in);
    combined_index_pulse_in = 1'b0;
    repeat (6) @(negedge clk_in);
    check(syncs, 3, "sync width");
    check(starts, 1, "count start");
    $display("test index done");
  endtask
  // button held past the syncs, then released long enough to settle
  task press;
    pattern_start_in = 1'b1;
    repeat (4) @(negedge clk_in);
    pattern_start_in = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
  // a run ends only at reset or a convergence stop, so each pick starts from a fresh reset
  task t_pattern;
    for (i = 0; i < 21; i++) begin
      reset_in = 1'b1;
      rotary_select_in = (i < 16) ? 3'h0 : (i < 20) ? 3'(i - 15) : 3'h1;
      dip_switch_in = (i < 16) ? 4'(i) : (i < 20) ? 4'h0 : 4'h2;
      e = (i < 16) ? i : (i < 20) ? i - 15 : 3;
      repeat (2) @(negedge clk_in);
      reset_in = 1'b0;
      repeat (3) @(negedge clk_in);
      press;
      check(pattern_number_out, 8'(e), "pattern");
      check(pattern_run_out, 1, "run started");
      press;
      check(pattern_run_out, !(i == 13 || i == 17), "toggle");
      check(pattern_number_out, 8'(e), "pattern kept");
    end
    $display("test pattern done");
  endtask
  initial begin
    {reset_in, machine_ready_status_n_in, streaming_ack_suppress_n_in} = 3'h7;
    {combined_index_pulse_in, latch_output_float_in, no_ink_in} = 3'h0;
    {pixel_width_select_in, processor_acknowledge_in, no_paper_in} = 3'h0;
    {processor_clear_strobe_in, byte_rejected_in, pattern_start_in} = 3'h0;
    rotary_select_in = 3'h0;
    dip_switch_in = 4'h0;
    {fail_count, comparisons} = 0;
    repeat (20) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge clk_in);
    t_fault;
    t_pixels;
    t_command;
    t_stream;
    t_index;
    t_pattern;
    give_verdict;
  end
endmodule
